/* fifo_port_pkg.sv */
package fifo_port_pkg;
	localparam int DATA_W = 36;
	localparam int ADDR_W = 11;
	localparam int OFS_W = 11;
	localparam int SERIAL_BITS = 2 * OFS_W;
	localparam logic [OFS_W-1:0] PRESET_LARGE = 11'h040;
	localparam logic [OFS_W-1:0] PRESET_SMALL = 11'h008;
	localparam logic [1:0] RESET_EDGES = 2'h2;
	localparam logic [1:0] SERIAL_END_EDGES = 2'h1;
	localparam logic [4:0] SERIAL_LAST = 5'h15;

	// offset mode as {hi, lo} at reset release
	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'h0,
		MODE_PRESET_SMALL = 2'h1,
		MODE_PRESET_LARGE = 2'h2,
		MODE_SERIAL = 2'h3
	} offset_mode_t;

	typedef enum {
		CFG_LATCH,
		CFG_WAIT,
		CFG_SHIFT,
		CFG_LOAD_FULL,
		CFG_LOAD_EMPTY,
		CFG_RUN
	} cfg_state_t;

	// control pins of one port, as sampled
	typedef struct packed {
		logic selectN;
		logic dirSel;
		logic strobe;
		logic mailSel;
	} port_ctrl_t;
endpackage : fifo_port_pkg

/* fifo_store.sv */
module fifo_store #(
	parameter int WIDTH = 36,
	parameter int AW = 11
) (
	input wire logic clk, // system clock
	input wire logic wrEn, // write strobe
	input wire logic [AW-1:0] wrAddr, // write address
	input wire logic [WIDTH-1:0] wrData, // write word
	input wire logic [AW-1:0] rdAddr, // read address
	output logic [WIDTH-1:0] rdData // word at read address
);
	logic [WIDTH-1:0] mem [2**AW];

	// no reset on the array; content is only valid behind the pointers
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	assign rdData = mem[rdAddr];
endmodule : fifo_store

/* clocked_fifo_port_control.sv */
module clocked_fifo_port_control
	import fifo_port_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int AW = ADDR_W
) (
	input wire logic clk, // system clock, 250 MHz
	input wire logic reset_n, // async master reset, active low
	input wire logic portAClock, // port-A clock, sampled
	input wire logic portBClock, // port-B clock, sampled
	input wire logic portADirSel, // high write, low read
	input wire logic portBDirSel, // low write, high read
	input wire logic portASelectN, // port-A chip select, low active
	input wire logic portBSelectN, // port-B chip select, low active
	input wire logic portAStrobe, // port-A enable
	input wire logic portBStrobe, // port-B enable
	input wire logic portAMailSel, // port-A mailbox select
	input wire logic portBMailSel, // port-B mailbox select
	input wire logic offsetModeHi, // mode hi / serial strobe (low active)
	input wire logic offsetModeLo, // mode lo / serial bit
	input wire logic [DW-1:0] portADataIn, // port-A pin level
	output logic [DW-1:0] portADataOut, // port-A drive value
	output logic portADataOe, // port-A drive enable
	input wire logic [DW-1:0] portBDataIn, // port-B pin level
	output logic [DW-1:0] portBDataOut, // port-B drive value
	output logic portBDataOe, // port-B drive enable
	output logic inputRoomFlag, // high: room to write
	output logic outputValidFlag, // high: output register valid
	output logic nearEmptyFlag, // low: near empty
	output logic nearFullFlag, // low: near full
	output logic aToBMailFullN, // low: A-to-B mail waiting
	output logic bToAMailFullN // low: B-to-A mail waiting
);
	// true when a port's enable cycle is selected
	function automatic logic strobed(input port_ctrl_t c);
		return !c.selectN && c.strobe;
	endfunction : strobed

	port_ctrl_t aCtrl;
	port_ctrl_t bCtrl;
	logic aClkPrev_reg;
	logic bClkPrev_reg;
	logic aRise;
	logic bRise;
	cfg_state_t cfgState_reg;
	offset_mode_t mode_reg;
	logic [1:0] waitCnt_reg;
	logic [4:0] bitCnt_reg;
	logic [SERIAL_BITS-1:0] shift_reg;
	logic [SERIAL_BITS-1:0] shiftNext;
	logic [OFS_W-1:0] nearEmptyOfs_reg;
	logic [OFS_W-1:0] nearFullOfs_reg;
	logic [AW:0] wrPtr_reg;
	logic [AW:0] rdPtr_reg;
	logic [AW:0] memCount;
	logic [DW-1:0] outWord_reg;
	logic [DW-1:0] aToBMailbox_reg;
	logic [DW-1:0] bToAMailbox_reg;
	logic [DW-1:0] rdData;
	logic aWrite;
	logic aRead;
	logic bWrite;
	logic bRead;
	logic fifoWrite;
	logic memWrite;
	logic fifoRead;
	logic offsetLoad;

	assign aCtrl = '{portASelectN, portADirSel, portAStrobe, portAMailSel};
	assign bCtrl = '{portBSelectN, portBDirSel, portBStrobe, portBMailSel};
	assign aRise = portAClock && !aClkPrev_reg;
	assign bRise = portBClock && !bClkPrev_reg;
	assign aWrite = aRise && strobed(aCtrl) && aCtrl.dirSel;
	assign aRead = aRise && strobed(aCtrl) && !aCtrl.dirSel;
	assign bWrite = bRise && strobed(bCtrl) && !bCtrl.dirSel;
	assign bRead = bRise && strobed(bCtrl) && bCtrl.dirSel;
	assign fifoWrite = aWrite && !aCtrl.mailSel && inputRoomFlag && !memCount[AW];
	assign offsetLoad = fifoWrite && (cfgState_reg inside {CFG_LOAD_FULL, CFG_LOAD_EMPTY});
	assign memWrite = fifoWrite && cfgState_reg == CFG_RUN;
	assign fifoRead = bRead && !bCtrl.mailSel && outputValidFlag;
	assign memCount = wrPtr_reg - rdPtr_reg;
	assign shiftNext = {shift_reg[SERIAL_BITS-2:0], offsetModeLo};

	// port clocks arrive as synchronous levels; held high in reset so no false rise at release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aClkPrev_reg <= 1'b1;
			bClkPrev_reg <= 1'b1;
		end else begin
			aClkPrev_reg <= portAClock;
			bClkPrev_reg <= portBClock;
		end
	end

	// configuration sequence; mode pins caught on the first clock after release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfgState_reg <= CFG_LATCH;
			mode_reg <= MODE_PARALLEL;
			waitCnt_reg <= RESET_EDGES;
			bitCnt_reg <= '0;
		end else begin
			unique case (cfgState_reg)
				CFG_LATCH: begin
					mode_reg <= offset_mode_t'({offsetModeHi, offsetModeLo});
					waitCnt_reg <= RESET_EDGES;
					cfgState_reg <= ({offsetModeHi, offsetModeLo} == MODE_SERIAL) ?
						CFG_SHIFT : CFG_WAIT;
				end
				CFG_WAIT: begin
					if (aRise) begin
						waitCnt_reg <= waitCnt_reg - 2'h1;
						if (waitCnt_reg == SERIAL_END_EDGES) begin
							cfgState_reg <= (mode_reg == MODE_PARALLEL) ? CFG_LOAD_FULL : CFG_RUN;
						end
					end
				end
				CFG_SHIFT: begin
					if (aRise && !offsetModeHi) begin
						bitCnt_reg <= bitCnt_reg + 5'h01;
						if (bitCnt_reg == SERIAL_LAST) begin
							waitCnt_reg <= SERIAL_END_EDGES;
							cfgState_reg <= CFG_WAIT;
						end
					end
				end
				CFG_LOAD_FULL: begin
					if (offsetLoad) begin
						cfgState_reg <= CFG_LOAD_EMPTY;
					end
				end
				CFG_LOAD_EMPTY: begin
					if (offsetLoad) begin
						cfgState_reg <= CFG_RUN;
					end
				end
				CFG_RUN: begin
					cfgState_reg <= CFG_RUN;
				end
			endcase
		end
	end

	// offset registers, eleven bits each; loaded by preset, port A or serial shift
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= '0;
			nearFullOfs_reg <= PRESET_SMALL;
			nearEmptyOfs_reg <= PRESET_SMALL;
		end else if (cfgState_reg == CFG_LATCH) begin
			if ({offsetModeHi, offsetModeLo} == MODE_PRESET_LARGE) begin
				nearFullOfs_reg <= PRESET_LARGE;
				nearEmptyOfs_reg <= PRESET_LARGE;
			end else begin
				nearFullOfs_reg <= PRESET_SMALL;
				nearEmptyOfs_reg <= PRESET_SMALL;
			end
		end else if (cfgState_reg == CFG_SHIFT && aRise && !offsetModeHi) begin
			shift_reg <= shiftNext;
			if (bitCnt_reg == SERIAL_LAST) begin
				nearFullOfs_reg <= shiftNext[SERIAL_BITS-1:OFS_W];
				nearEmptyOfs_reg <= shiftNext[OFS_W-1:0];
			end
		end else if (offsetLoad && cfgState_reg == CFG_LOAD_FULL) begin
			nearFullOfs_reg <= portADataIn[OFS_W-1:0];
		end else if (offsetLoad) begin
			nearEmptyOfs_reg <= portADataIn[OFS_W-1:0];
		end
	end

	fifo_store #(
		.WIDTH(DW),
		.AW(AW)
	) store (
		.clk(clk),
		.wrEn(memWrite),
		.wrAddr(wrPtr_reg[AW-1:0]),
		.wrData(portADataIn),
		.rdAddr(rdPtr_reg[AW-1:0]),
		.rdData(rdData)
	);

	// write side touches only the write pointer, read side only the read pointer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_reg <= '0;
		end else if (memWrite) begin
			wrPtr_reg <= wrPtr_reg + 1'b1;
		end
	end

	// output register: auto-loads when empty, else only on a selected read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdPtr_reg <= '0;
			outWord_reg <= '0;
			outputValidFlag <= 1'b0;
		end else if (bRise && (!outputValidFlag || fifoRead)) begin
			if (memCount != '0) begin
				outWord_reg <= rdData;
				rdPtr_reg <= rdPtr_reg + 1'b1;
				outputValidFlag <= 1'b1;
			end else begin
				outputValidFlag <= 1'b0;
			end
		end
	end

	// level flags from the memory fill; input room held low until the offset load or run state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			inputRoomFlag <= 1'b0;
			nearEmptyFlag <= 1'b0;
			nearFullFlag <= 1'b1;
		end else begin
			inputRoomFlag <= (cfgState_reg inside {CFG_LOAD_FULL, CFG_LOAD_EMPTY, CFG_RUN}) &&
				!memCount[AW];
			nearEmptyFlag <= memCount > {1'b0, nearEmptyOfs_reg};
			nearFullFlag <= memCount < (AW+1)'((2**AW) - nearFullOfs_reg);
		end
	end

	// mailboxes; a write arriving with the far-side read wins, so no mail is lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aToBMailbox_reg <= '0;
			bToAMailbox_reg <= '0;
			aToBMailFullN <= 1'b1;
			bToAMailFullN <= 1'b1;
		end else begin
			if (aWrite && aCtrl.mailSel) begin
				aToBMailbox_reg <= portADataIn;
				aToBMailFullN <= 1'b0;
			end else if (bRead && bCtrl.mailSel) begin
				aToBMailFullN <= 1'b1;
			end
			if (bWrite && bCtrl.mailSel) begin
				bToAMailbox_reg <= portBDataIn;
				bToAMailFullN <= 1'b0;
			end else if (aRead && aCtrl.mailSel) begin
				bToAMailFullN <= 1'b1;
			end
		end
	end

	// pin drive registered, so enables follow the selects by one clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			portADataOut <= '0;
			portADataOe <= 1'b0;
			portBDataOut <= '0;
			portBDataOe <= 1'b0;
		end else begin
			portADataOut <= bToAMailbox_reg;
			portADataOe <= !portASelectN && !portADirSel;
			portBDataOut <= portBMailSel ? aToBMailbox_reg : outWord_reg;
			portBDataOe <= !portBSelectN && portBDirSel;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	portA_drive_a: assert property (portADataOe == $past(!portASelectN && !portADirSel))
		else $error("port A drive enable wrong");
	portB_drive_a: assert property (portBDataOe == $past(!portBSelectN && portBDirSel))
		else $error("port B drive enable wrong");
	write_gate_a: assert property (memWrite |-> inputRoomFlag && portADirSel && !portAMailSel)
		else $error("memory write without its conditions");
	write_count_a: assert property (memWrite && !(bRise && memCount != '0) |=>
		memCount == $past(memCount) + 1'b1)
		else $error("write did not advance fill");
	read_gate_a: assert property (bRise && bCtrl.dirSel && strobed(bCtrl) && !portBMailSel
		&& !outputValidFlag |=> rdPtr_reg == $past(rdPtr_reg) || $past(memCount) != '0)
		else $error("read while output invalid");
	mail_flag_a: assert property (aWrite && portAMailSel |=> !aToBMailFullN)
		else $error("A-to-B mail flag not set");
	mail_read_a: assert property (aRead && portAMailSel && !(bWrite && portBMailSel)
		|=> bToAMailFullN)
		else $error("B-to-A mail flag not released");
	serial_room_a: assert property (cfgState_reg == CFG_SHIFT |=> !inputRoomFlag)
		else $error("input room during serial load");
	preset_wait_a: assert property ($rose(cfgState_reg == CFG_WAIT) |-> !inputRoomFlag [*2])
		else $error("input room too early");
	offset_load_a: assert property (offsetLoad && cfgState_reg == CFG_LOAD_FULL
		|=> nearFullOfs_reg == $past(portADataIn[OFS_W-1:0]) && cfgState_reg == CFG_LOAD_EMPTY)
		else $error("near-full offset not loaded");

	// offset programming, fill and mail guards
	mode_latch_a: assert property (cfgState_reg == CFG_LATCH |=> mode_reg == $past({offsetModeHi, offsetModeLo}))
		else $error("offset mode not latched");
	preset_large_a: assert property (cfgState_reg == CFG_LATCH
		&& {offsetModeHi, offsetModeLo} == MODE_PRESET_LARGE |=> nearFullOfs_reg == PRESET_LARGE && nearEmptyOfs_reg == PRESET_LARGE)
		else $error("large preset not loaded");
	preset_small_a: assert property (cfgState_reg == CFG_LATCH
		&& {offsetModeHi, offsetModeLo} == MODE_PRESET_SMALL |=> nearFullOfs_reg == PRESET_SMALL && nearEmptyOfs_reg == PRESET_SMALL)
		else $error("small preset not loaded");
	serial_load_a: assert property (cfgState_reg == CFG_SHIFT && aRise && !offsetModeHi && bitCnt_reg == SERIAL_LAST
		|=> {nearFullOfs_reg, nearEmptyOfs_reg} == {$past(shift_reg[SERIAL_BITS-2:0]), $past(offsetModeLo)})
		else $error("serial offsets not loaded");
	full_gate_a: assert property (memWrite |-> !memCount[AW])
		else $error("write into full memory");
	mail_back_a: assert property (bWrite && portBMailSel |=> !bToAMailFullN)
		else $error("B-to-A mail flag not set");
endmodule : clocked_fifo_port_control

/* port_clock_model.sv */
module port_clock_model (
	input wire logic clk, // system clock
	input wire logic runA, // port-A clock runs
	input wire logic runB, // port-B clock runs
	output logic portAClock, // port-A clock level
	output logic portBClock, // port-B clock level
	output logic aTake, // coming clk edge sees a port-A rise
	output logic bTake // coming clk edge sees a port-B rise
);
	timeunit 1ns;
	timeprecision 1ps;
	logic aLvl = 1'b0;
	logic bLvl = 1'b0;
	logic aPrev = 1'b0;
	logic bPrev = 1'b0;
	// rise every two clk, the closest spacing the ports accept
	always @(posedge clk) begin
		if (runA) aLvl <= ~aLvl;
		if (runB) bLvl <= ~bLvl;
		aPrev <= aLvl;
		bPrev <= bLvl;
	end
	// the bench keeps both running through reset
	assign portAClock = aLvl;
	assign portBClock = bLvl;
	assign aTake = aLvl & ~aPrev;
	assign bTake = bLvl & ~bPrev;
endmodule : port_clock_model

/* tb.sv */
module tb import fifo_port_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rstN;
	port_ctrl_t ctlA;
	port_ctrl_t ctlB;
	logic modeHi, modeLo, runA, runB, aTake, bTake, portAClock, portBClock;
	logic [35:0] aDrive, bDrive, aOut, bOut, aIn, bIn;
	logic aOe, bOe, irF, ovF, neF, nfF, abN, baN;
	int errTotal;
	int checksDone;
	// serial stream: near-full 2044 then near-empty 1, in range
	localparam logic [21:0] SER = {11'h7fc, 11'h001};

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// shared pins: whoever enables drives the level
	assign aIn = aOe ? aOut : aDrive;
	assign bIn = bOe ? bOut : bDrive;

	port_clock_model i_far (.clk(clk), .runA(runA), .runB(runB), .portAClock(portAClock),
		.portBClock(portBClock), .aTake(aTake), .bTake(bTake));

	clocked_fifo_port_control i_dut (
		.clk(clk), .reset_n(rstN), .portAClock(portAClock), .portBClock(portBClock),
		.portADirSel(ctlA.dirSel), .portBDirSel(ctlB.dirSel),
		.portASelectN(ctlA.selectN), .portBSelectN(ctlB.selectN),
		.portAStrobe(ctlA.strobe), .portBStrobe(ctlB.strobe),
		.portAMailSel(ctlA.mailSel), .portBMailSel(ctlB.mailSel),
		.offsetModeHi(modeHi), .offsetModeLo(modeLo),
		.portADataIn(aIn), .portADataOut(aOut), .portADataOe(aOe),
		.portBDataIn(bIn), .portBDataOut(bOut), .portBDataOe(bOe),
		.inputRoomFlag(irF), .outputValidFlag(ovF), .nearEmptyFlag(neF),
		.nearFullFlag(nfF), .aToBMailFullN(abN), .bToAMailFullN(baN));

	task automatic printVerdict();
		if (errTotal == 0 && checksDone > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : printVerdict

	task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// bounded waits; running out ends the run
	task automatic waitTake(input logic onB);
		for (int n = 0; n < 32; n++) begin
			@(posedge clk);
			if (onB ? bTake : aTake) return;
		end
		chk("port clock rise", 36'h0, 36'h1);
		printVerdict();
	endtask : waitTake

	task automatic waitHigh(ref logic f);
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (f === 1'b1) return;
		end
		chk("flag rise", 36'h0, 36'h1);
		printVerdict();
	endtask : waitHigh

	// controls held until the taking edge, strobe dropped there
	task automatic aOp(input logic [3:0] c, input logic [35:0] d);
		ctlA <= port_ctrl_t'(c);
		aDrive <= d;
		waitTake(1'b0);
		ctlA.strobe <= 1'b0;
		tick(1);
	endtask : aOp

	task automatic bOp(input logic [3:0] c, input logic [35:0] d);
		ctlB <= port_ctrl_t'(c);
		bDrive <= d;
		waitTake(1'b1);
		ctlB.strobe <= 1'b0;
		tick(1);
	endtask : bOp

	// port B stops after release so memory fill stays where writes put it
	task automatic rst(input int n, input logic [1:0] m);
		rstN <= 1'b0;
		runB <= 1'b1;
		{modeHi, modeLo} <= m;
		tick(n);
		chk("room in reset", irF, 1'b0);
		chk("near empty in reset", neF, 1'b0);
		chk("near full in reset", nfF, 1'b1);
		chk("mail flags in reset", {abN, baN}, 2'h3);
		rstN <= 1'b1;
		runB <= 1'b0;
		tick(3);
		chk("room after release", irF, 1'b0);
	endtask : rst

	initial begin
		ctlA = port_ctrl_t'(4'hc);
		ctlB = port_ctrl_t'(4'hc);
		{modeHi, modeLo, runA, runB, rstN} = 5'h1c;
		aDrive = 36'h0;
		bDrive = 36'h0;
		errTotal = 0;
		checksDone = 0;
		@(posedge clk);
		rst(5, 2'h0);
		waitHigh(irF);
		// offsets first, junk above bit 10: near-full 2044, near-empty 2
		aOp(4'h6, 36'hffffff7fc);
		aOp(4'h6, 36'h123456002);
		for (int i = 0; i < 4; i++) begin
			aOp(4'h6, 36'h0a0 + i);
			tick(3);
			chk("near empty fill", neF, i >= 2);
			chk("near full fill", nfF, i < 3);
		end
		ctlB <= port_ctrl_t'(4'h4);
		runB <= 1'b1;
		waitHigh(ovF);
		tick(2);
		chk("first word out", bOut, 36'h0a0);
		chk("port b drive", bOe, 1'b1);
		bOp(4'h6, 36'h0);
		tick(2);
		chk("next word out", bOut, 36'h0a1);
		chk("near empty drain", neF, 1'b0);
		chk("output still valid", ovF, 1'b1);
		ctlB <= port_ctrl_t'(4'h0);
		tick(3);
		chk("port b float", bOe, 1'b0);
		// mailboxes both ways
		aOp(4'h7, 36'h5a5a5a5a5);
		tick(2);
		chk("a to b full", abN, 1'b0);
		ctlB <= port_ctrl_t'(4'h5);
		tick(3);
		chk("b shows mail", bOut, 36'h5a5a5a5a5);
		bOp(4'h7, 36'h0);
		tick(2);
		chk("a to b read", abN, 1'b1);
		// turn the pins around first; the drive enable drops one clock late
		ctlB <= port_ctrl_t'(4'h1);
		tick(2);
		bOp(4'h3, 36'h0c3c3c3c3);
		tick(2);
		chk("b to a full", baN, 1'b0);
		ctlA <= port_ctrl_t'(4'h1);
		tick(3);
		chk("port a drive", aOe, 1'b1);
		chk("a shows mail", aOut, 36'h0c3c3c3c3);
		aOp(4'h3, 36'h0);
		tick(2);
		chk("b to a read", baN, 1'b1);
		ctlA <= port_ctrl_t'(4'h8);
		tick(3);
		chk("a float select", aOe, 1'b0);
		ctlA <= port_ctrl_t'(4'h4);
		tick(3);
		chk("a float dir", aOe, 1'b0);
		ctlB <= port_ctrl_t'(4'hc);
		// presets 8 then 64: level flips on the word after that many
		for (int k = 1; k <= 2; k++) begin
			rst(16, k[1:0]);
			waitHigh(irF);
			for (int i = 0; i <= (k == 1 ? 8 : 64); i++) begin
				aOp(4'h6, 36'h100 + i);
				tick(3);
				chk("preset level", neF, i >= (k == 1 ? 8 : 64));
			end
		end
		// serial: a write while room is low must be dropped
		rst(16, 2'h3);
		aOp(4'h6, 36'h0ff);
		for (int i = 21; i >= 0; i--) begin
			modeHi <= 1'b0;
			modeLo <= SER[i];
			waitTake(1'b0);
			chk("room while shifting", irF, 1'b0);
		end
		modeHi <= 1'b1;
		waitHigh(irF);
		for (int i = 0; i < 2; i++) begin
			aOp(4'h6, 36'h0b0 + i);
			tick(3);
			chk("serial offset", neF, i == 1);
		end
		printVerdict();
	end
endmodule : tb
